/* File: logic/adc_output_port_config.sv */
// Result output port and configuration logic of the sampling converter
// Operation
// - Byte order low puts the low byte on lines 7..0, high swaps bytes.
// - Coding select high gives straight binary, low inverts the MSB.
// - Fast high, low power low: fastest mode; host keeps a minimum rate.
// - Low power high with fast low is the reduced power mode.
// - Interface select low uses the parallel port, high the serial port.
// - Data bits 0 and 1 drive in parallel mode and float in serial mode.
// - In parallel mode the shared pins 2, 3, 4, 5 and 7 drive result data bits.
// - Pins 2 and 3 slow the internal clock only in read-after-convert mode.
// - Pin 4 is a data bit in parallel mode, the clock source in serial.
// - Clock source high makes the host clock the serial data.
// - Internal clock: read mode high shifts the last word during convert.
// - External clock: the chain input reaches the output after 16 clocks.
// - Frame polarity low gives active-high frame sync, high active-low.
`timescale 1ns/1ps
`include "adc_port_defines.svh"

module adc_output_port_config
  import adc_port_pkg::*;
#(
  parameter int WIDTH = `RESULT_W
) (
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  input  wire logic        byte_order_select_i,
  input  wire logic        output_coding_select_i,
  input  wire logic        fast_mode_select_i,
  input  wire logic        low_power_select_i,
  input  wire logic        interface_select_i,
  input  wire logic        conv_start_i,
  input  wire logic        result_valid_i,
  input  wire logic [15:0] result_data_i,
  output logic             result_ready_o,
  input  wire logic [15:0] data_i,
  output logic [15:0]      data_o,
  output logic [15:0]      data_oe_o,
  input  wire logic        sclk_i,
  output logic             sclk_o,
  output logic             sclk_oe_o,
  output logic             serial_result_out_o,
  output logic             frame_sync_o,
  output conv_mode_t       conv_mode_o,
  output logic             min_rate_required_o
);

  // -------------------------------------------------------------
  // Elaboration checks
  // -------------------------------------------------------------
  // Pin map, byte split and frame counter serve a 16-bit word only
  if (WIDTH != `RESULT_W) begin : g_bad_width
    $error("adc_output_port_config: WIDTH must be 16");
  end
  if (`RESULT_MSB != WIDTH - 1) begin : g_bad_msb
    $error("adc_output_port_config: MSB position does not match WIDTH");
  end
  if (`FRAME_LAST_BIT != WIDTH - 1) begin : g_bad_frame
    $error("adc_output_port_config: frame length does not match WIDTH");
  end
  if (`BYTE_HI_LO != `BYTE_LO_HI + 1) begin : g_bad_bytes
    $error("adc_output_port_config: byte split is not contiguous");
  end

  // -------------------------------------------------------------
  // Result buffer
  // -------------------------------------------------------------
  logic        buf_valid;
  logic [15:0] buf_data;
  logic        buf_take;

  // Absorbs up to two words while a serial frame is running
  result_buffer #(
    .WIDTH (WIDTH),
    .DEPTH (2)
  ) u_result_buffer (
    .clk_sys_i   (clk_sys_i),
    .srst_i      (srst_i),
    .in_valid_i  (result_valid_i),
    .in_data_i   (result_data_i),
    .in_ready_o  (result_ready_o),
    .out_valid_o (buf_valid),
    .out_data_o  (buf_data),
    .out_ready_i (buf_take)
  );

  // -------------------------------------------------------------
  // Mode decode
  // -------------------------------------------------------------
  port_state_t q;
  port_state_t d;
  logic        serial;
  logic        ext_clk;
  logic        read_during;
  logic        frame_pol;
  logic        chain_in;
  logic [1:0]  div_sel;
  logic [7:0]  half_cnt;
  logic [15:0] coded;
  logic        pop;
  logic        ext_rise;
  logic        int_fall;

  always_comb begin
    // Shared pins carry serial controls only with serial selected
    serial      = interface_select_i;
    ext_clk     = serial && data_i[`PIN_CLK_SRC];
    read_during = serial && !ext_clk && data_i[`PIN_CHAIN];
    frame_pol   = data_i[`PIN_FRAME_POL];
    chain_in    = data_i[`PIN_CHAIN];
    // Divider pins count only in read-after-convert master mode
    if (serial && !ext_clk && !data_i[`PIN_CHAIN]) begin
      div_sel = {data_i[`PIN_DIV_HI], data_i[`PIN_DIV_LO]};
    end else begin
      div_sel = 2'b00;
    end
    // Half period in system clocks: one, two, four or eight
    half_cnt = `SCLK_HALF_BASE << div_sel;
  end

  // -------------------------------------------------------------
  // Output coding
  // -------------------------------------------------------------
  always_comb begin
    // Coding is fixed when the word leaves the buffer
    coded = buf_data;
    if (!output_coding_select_i) begin
      coded[`RESULT_MSB] = ~buf_data[`RESULT_MSB];
    end
  end

  // -------------------------------------------------------------
  // Buffer drain
  // -------------------------------------------------------------
  always_comb begin
    // Parallel and read-during modes take a word as soon as it arrives;
    // a running frame leaves the rest waiting in the buffer
    if (!serial || read_during) begin
      buf_take = 1'b1;
    end else begin
      buf_take = (q.state == SER_IDLE);
    end
    pop = buf_valid && buf_take;
  end

  // -------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------
  always_comb begin
    d        = q;
    ext_rise = 1'b0;
    int_fall = 1'b0;

    // -----------------------------------------------------------
    // Conversion mode
    // -----------------------------------------------------------
    // Both selects equal fall back to the normal mode
    if (fast_mode_select_i && !low_power_select_i) begin
      d.mode = MODE_FAST;
    end else if (low_power_select_i && !fast_mode_select_i) begin
      d.mode = MODE_LOW_POWER;
    end else begin
      d.mode = MODE_NORMAL;
    end
    d.min_rate = (d.mode == MODE_FAST);

    // -----------------------------------------------------------
    // Parallel word
    // -----------------------------------------------------------
    // Swap acts on the held word and shows one edge after the select
    if (pop && !serial) begin
      d.word = coded;
    end
    if (byte_order_select_i) begin
      d.par = {d.word[`BYTE_LO_HI:0],
               d.word[`RESULT_MSB:`BYTE_HI_LO]};
    end else begin
      d.par = d.word;
    end
    // Serial mode releases the whole bus; serial signals have own ports
    if (serial) begin
      d.oe = `OE_SERIAL;
    end else begin
      d.oe = `OE_PARALLEL;
    end

    // -----------------------------------------------------------
    // Serial engine
    // -----------------------------------------------------------
    d.sclk_in = sclk_i;
    if (!serial) begin
      d.state   = SER_IDLE;
      d.sclk    = 1'b0;
      d.div_cnt = `DIV_CNT_ZERO;
      d.held_ok = 1'b0;
    end else if (ext_clk) begin
      d.sclk    = 1'b0;
      d.div_cnt = `DIV_CNT_ZERO;
      // Host clock is sampled once per cycle, so a rise acts at the first
      // edge that samples it high and each host level must stand one cycle at least
      ext_rise  = sclk_i && !q.sclk_in;
      if (ext_rise) begin
        d.shreg = {q.shreg[`RESULT_MSB-1:0], chain_in};
        if (q.state == SER_SHIFT) begin
          if (q.bit_cnt == `FRAME_LAST_BIT) begin
            d.state = SER_IDLE;
          end else begin
            d.bit_cnt = q.bit_cnt + `BIT_CNT_ONE;
          end
        end
      end
      // A new word restarts the frame; chain bits fill in behind it
      if (pop) begin
        d.shreg   = coded;
        d.state   = SER_SHIFT;
        d.bit_cnt = '0;
      end
    end else begin
      // Read during convert: the newest word waits in the hold
      // register until the next conversion starts a frame
      if (pop && read_during) begin
        d.held    = coded;
        d.held_ok = 1'b1;
      end
      case (q.state)
        SER_IDLE: begin
          // Clock parked low between frames
          d.sclk    = 1'b0;
          d.div_cnt = `DIV_CNT_ZERO;
          d.bit_cnt = '0;
          if (read_during) begin
            if (conv_start_i && q.held_ok) begin
              d.shreg = q.held;
              d.state = SER_SHIFT;
            end
          end else if (pop) begin
            d.shreg = coded;
            d.state = SER_SHIFT;
          end
        end
        SER_SHIFT: begin
          // Toggle after a half period of the divided clock
          if (q.div_cnt + `DIV_CNT_ONE >= half_cnt) begin
            d.div_cnt = `DIV_CNT_ZERO;
            d.sclk    = ~q.sclk;
            int_fall  = q.sclk;
          end else begin
            d.div_cnt = q.div_cnt + `DIV_CNT_ONE;
          end
          // Bits advance on the fall so each stands across a rise
          if (int_fall) begin
            if (q.bit_cnt == `FRAME_LAST_BIT) begin
              d.state = SER_IDLE;
            end else begin
              d.shreg   = {q.shreg[`RESULT_MSB-1:0], 1'b0};
              d.bit_cnt = q.bit_cnt + `BIT_CNT_ONE;
            end
          end
        end
        default: begin
          // Unused encodings return to idle
          d.state = SER_IDLE;
        end
      endcase
    end

    // -----------------------------------------------------------
    // Frame outputs
    // -----------------------------------------------------------
    // Sync follows the next state so it lines up with the first bit
    d.sclk_oe = serial && !ext_clk;
    d.serial_result_out   = serial && d.shreg[`RESULT_MSB];
    if (serial) begin
      d.sync = (d.state == SER_SHIFT) ^ frame_pol;
    end else begin
      d.sync = 1'b0;
    end
  end

  // -------------------------------------------------------------
  // State register
  // -------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      // Bus stays released for one edge after reset
      q       <= '0;
      q.state <= SER_IDLE;
      q.mode  <= MODE_NORMAL;
    end else begin
      q <= d;
    end
  end

  // -------------------------------------------------------------
  // Outputs
  // -------------------------------------------------------------
  // Every output is a register bit
  assign data_o              = q.par;
  assign data_oe_o           = q.oe;
  assign sclk_o              = q.sclk;
  assign sclk_oe_o           = q.sclk_oe;
  assign serial_result_out_o = q.serial_result_out;
  assign frame_sync_o        = q.sync;
  assign conv_mode_o         = q.mode;
  assign min_rate_required_o = q.min_rate;

endmodule : adc_output_port_config

/* File: logic/adc_port_defines.svh */
// Constants for the converter result output port
`ifndef ADC_PORT_DEFINES_SVH
`define ADC_PORT_DEFINES_SVH

// ---------------------------------------------------------------
// Result word
// ---------------------------------------------------------------
`define RESULT_W         16
`define RESULT_MSB       15
`define BYTE_LO_HI       7
`define BYTE_HI_LO       8
`define FRAME_LAST_BIT   5'h0f
`define BIT_CNT_ONE      5'h01

// ---------------------------------------------------------------
// Shared data pins read as inputs in serial mode
// ---------------------------------------------------------------
`define PIN_DIV_LO       2
`define PIN_DIV_HI       3
`define PIN_CLK_SRC      4
`define PIN_FRAME_POL    5
`define PIN_CHAIN        7

// ---------------------------------------------------------------
// Pin enables
// ---------------------------------------------------------------
`define OE_PARALLEL      16'hffff
`define OE_SERIAL        16'h0000

// ---------------------------------------------------------------
// Internal serial clock
// ---------------------------------------------------------------
`define SCLK_HALF_BASE   8'h01
`define DIV_CNT_ONE      8'h01
`define DIV_CNT_ZERO     8'h00

`endif

/* File: logic/adc_port_pkg.sv */
// Types shared by the converter result output port
package adc_port_pkg;

  // -------------------------------------------------------------
  // Conversion mode
  // -------------------------------------------------------------
  typedef enum logic [1:0] {
    MODE_NORMAL,
    MODE_FAST,
    MODE_LOW_POWER
  } conv_mode_t;

  // -------------------------------------------------------------
  // Serial frame state
  // -------------------------------------------------------------
  typedef enum logic {
    SER_IDLE,
    SER_SHIFT
  } ser_state_t;

  // -------------------------------------------------------------
  // Register state of the port
  // -------------------------------------------------------------
  typedef struct packed {
    ser_state_t  state;
    logic [15:0] word;
    logic [15:0] par;
    logic [15:0] oe;
    logic [15:0] held;
    logic        held_ok;
    logic [15:0] shreg;
    logic [4:0]  bit_cnt;
    logic [7:0]  div_cnt;
    logic        sclk;
    logic        sclk_oe;
    logic        sclk_in;
    logic        serial_result_out;
    logic        sync;
    conv_mode_t  mode;
    logic        min_rate;
  } port_state_t;

endpackage : adc_port_pkg

/* File: logic/result_buffer.sv */
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
`include "adc_port_defines.svh"

module result_buffer #(
  parameter int WIDTH = `RESULT_W,
  parameter int DEPTH = 2
) (
  input  wire logic             clk_sys_i,
  input  wire logic             srst_i,
  input  wire logic             in_valid_i,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  in_ready_o,
  output logic                  out_valid_o,
  output logic [WIDTH-1:0]      out_data_o,
  input  wire logic             out_ready_i
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  if (DEPTH != 2 || WIDTH < 1) begin : g_bad_param
    $error("result_buffer: DEPTH must be 2 and WIDTH positive");
  end

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [AW:0]                 cnt;
    logic                        ready;
  } buf_state_t;

  buf_state_t q;
  buf_state_t d;
  logic       push;
  logic       pop;

  // -------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------
  always_comb begin
    d    = q;
    push = in_valid_i && q.ready;
    pop  = out_valid_o && out_ready_i;
    if (push) begin
      d.mem[q.wr] = in_data_i;
      d.wr        = q.wr + AW'(1);
    end
    if (pop) begin
      d.rd = q.rd + AW'(1);
    end
    d.cnt   = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
    d.ready = (d.cnt != (AW+1)'(DEPTH));
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      q       <= '0;
      q.ready <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign in_ready_o  = q.ready;
  assign out_valid_o = (q.cnt != '0);
  assign out_data_o  = q.mem[q.rd];

endmodule : result_buffer

/* File: testbench/adc_port_checker.sv */
// Port assertions for the result output port
`timescale 1ns/1ps

module adc_port_checker
  import adc_port_pkg::*;
#(
  parameter int WIDTH = 16
) (
  input wire logic        clk_sys_i,
  input wire logic        srst_i,
  input wire logic        fast_mode_select_i,
  input wire logic        low_power_select_i,
  input wire logic        interface_select_i,
  input wire logic [15:0] data_i,
  input wire logic [15:0] data_oe_o,
  input wire logic        sclk_o,
  input wire logic        sclk_oe_o,
  input wire logic        serial_result_out_o,
  input wire logic        frame_sync_o,
  input wire conv_mode_t  conv_mode_o,
  input wire logic        min_rate_required_o
);
  // -----------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);
  wire logic ser = interface_select_i;
  wire logic fst = fast_mode_select_i;
  wire logic lpw = low_power_select_i;

  chk_oe_serial: assert property (
    ser && $past(ser) |-> data_oe_o == 16'h0000)
    else $error("data pins driven in serial mode");
  chk_oe_parallel: assert property (
    !ser && !$past(ser) && !$past(srst_i) |-> data_oe_o == 16'hffff)
    else $error("data pins not driven");
  chk_mode_fast: assert property (
    fst && !lpw |=> conv_mode_o == MODE_FAST && min_rate_required_o)
    else $error("fast mode not entered");
  chk_mode_low_power: assert property (
    lpw && !fst |=> conv_mode_o == MODE_LOW_POWER && !min_rate_required_o)
    else $error("low power mode not entered");
  chk_mode_normal: assert property (
    !lpw && !fst |=> conv_mode_o == MODE_NORMAL && !min_rate_required_o)
    else $error("normal mode not entered");
  chk_clk_src_ser: assert property (
    ser |=> sclk_oe_o == !$past(data_i[4]))
    else $error("serial clock enable wrong");
  chk_par_quiet: assert property (
    !ser |=> !sclk_oe_o && !frame_sync_o && !serial_result_out_o)
    else $error("serial pins active");
  chk_sclk_slow: assert property (
    ser && !data_i[7] && !data_i[4] && data_i[3:2] == 2'b11
    && $rose(sclk_o) |-> sclk_o [*8] ##1 !sclk_o)
    else $error("divided clock wrong");
  chk_sclk_fixed: assert property (
    ser && data_i[7] && !data_i[4] && $rose(sclk_o) |=> !sclk_o)
    else $error("divider not ignored");
endmodule : adc_port_checker

bind adc_output_port_config adc_port_checker #(.WIDTH(WIDTH)) i_chk (
  .clk_sys_i, .srst_i, .fast_mode_select_i, .low_power_select_i,
  .interface_select_i, .data_i, .data_oe_o, .sclk_o, .sclk_oe_o,
  .serial_result_out_o, .frame_sync_o, .conv_mode_o, .min_rate_required_o);

/* File: testbench/host_model.sv */
// Host controller that clocks and collects serial results
`timescale 1ns/1ps

module host_model (
  input  wire logic  clk_sys_i,
  input  wire logic  run_i,
  input  wire logic  sclk_int_i,
  input  wire logic  serial_result_out_i,
  output logic       sclk_ext_o,
  output logic       busy_o,
  output logic [16:0] rx_o
);
  initial begin
    sclk_ext_o = 1'b0;
    busy_o = 1'b0;
    rx_o = 17'h00000;
  end
  // Internal clock: bit is stable at the rising edge
  always @(posedge sclk_int_i) rx_o <= {rx_o[15:0], serial_result_out_i};
  // External clock: 17 periods, sampled before each rise
  always @(posedge run_i) begin
    busy_o <= 1'b1;
    repeat (17) begin
      repeat (4) @(posedge clk_sys_i);
      rx_o <= {rx_o[15:0], serial_result_out_i};
      sclk_ext_o <= 1'b1;
      repeat (4) @(posedge clk_sys_i);
      sclk_ext_o <= 1'b0;
    end
    busy_o <= 1'b0;
  end
endmodule : host_model

/* File: testbench/tb.sv */
// Self-checking testbench of the result output port
`timescale 1ns/1ps

module tb;
  import adc_port_pkg::*;
  logic clk_sys_i = 0, srst_i = 1, swap = 0, coding = 1, fast = 0, lpw = 0;
  logic ser = 0, conv = 0, vld = 0, ready, sclk_o, sclk_oe, serial_result_out, sync;
  logic run = 0, sclk_ext, busy, min_rate;
  logic [15:0] dat = 16'h0000, pins = 16'h0000, data_o, oe;
  logic [16:0] rx;
  conv_mode_t mode;
  int error_cnt = 0, num_checks = 0;
  conv_mode_t exp_mode [3] = '{MODE_NORMAL, MODE_FAST, MODE_LOW_POWER};

  adc_output_port_config i_dut (.clk_sys_i, .srst_i,
    .byte_order_select_i(swap), .output_coding_select_i(coding),
    .fast_mode_select_i(fast), .low_power_select_i(lpw),
    .interface_select_i(ser), .conv_start_i(conv), .result_valid_i(vld),
    .result_data_i(dat), .result_ready_o(ready), .data_i(pins),
    .data_o(data_o), .data_oe_o(oe), .sclk_i(sclk_ext), .sclk_o(sclk_o),
    .sclk_oe_o(sclk_oe), .serial_result_out_o(serial_result_out), .frame_sync_o(sync),
    .conv_mode_o(mode), .min_rate_required_o(min_rate));
  host_model i_host (.clk_sys_i, .run_i(run), .sclk_int_i(sclk_o),
    .serial_result_out_i(serial_result_out), .sclk_ext_o(sclk_ext), .busy_o(busy), .rx_o(rx));

  initial forever #25 clk_sys_i = ~clk_sys_i;

  // -----------------------------------------------------------
  // Tasks
  // -----------------------------------------------------------
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("Error %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask : chk
  task automatic send(input logic [15:0] w);
    @(negedge clk_sys_i) vld = 1;
    dat = w;
    for (int k = 0; k < 1000 && ready !== 1'b1; k++) @(negedge clk_sys_i);
    @(negedge clk_sys_i) vld = 0;
  endtask : send
  task automatic wait_for(input bit on_sync, input logic lvl);
    int k;
    for (k = 0; k < 1000 && (on_sync ? sync : busy) !== lvl; k++)
      @(negedge clk_sys_i);
    chk(k < 1000, 1);
  endtask : wait_for
  task automatic frame(input logic pol, input logic [15:0] w);
    wait_for(1, ~pol);
    wait_for(1, pol);
    chk(rx[15:0], w);
  endtask : frame
  task final_report;
    $display("Checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report

  // -----------------------------------------------------------
  // Tests
  // -----------------------------------------------------------
  initial begin
    repeat (3) @(negedge clk_sys_i);
    srst_i = 0;
    for (int i = 0; i < 3; i++) begin
      @(negedge clk_sys_i) fast = (i == 1);
      lpw = (i == 2);
      repeat (2) @(negedge clk_sys_i);
      chk({mode, min_rate}, {exp_mode[i], i == 1});
    end
    send(16'h12a5);
    repeat (2) @(negedge clk_sys_i);
    chk({oe, 1'b0}, 17'h1fffe);
    chk(data_o, 16'h12a5);
    swap = 1;
    repeat (2) @(negedge clk_sys_i);
    chk(data_o, 16'ha512);
    swap = 0;
    coding = 0;
    send(16'h12a5);
    repeat (2) @(negedge clk_sys_i);
    chk(data_o, 16'h92a5);
    coding = 1;
    ser = 1;
    repeat (2) @(negedge clk_sys_i);
    chk(oe, 16'h0000);
    chk(sync, 0);
    send(16'hc35a);
    frame(0, 16'hc35a);
    pins = 16'h002c;
    send(16'h8001);
    send(16'h7ffe);
    send(16'h0f0f);
    @(negedge clk_sys_i);
    chk(ready, 0);
    frame(1, 16'h8001);
    frame(1, 16'h7ffe);
    frame(1, 16'h0f0f);
    chk(ready, 1);
    pins = 16'h008c;
    send(16'h5aa5);
    repeat (20) @(negedge clk_sys_i);
    chk(sync, 0);
    conv = 1;
    @(negedge clk_sys_i) conv = 0;
    frame(0, 16'h5aa5);
    pins = 16'h0090;
    send(16'h3c01);
    wait_for(1, 1);
    run = 1;
    wait_for(0, 1);
    wait_for(0, 0);
    run = 0;
    chk(rx, {16'h3c01, 1'b1});
    final_report;
  end

  initial begin
    repeat (20000) @(posedge clk_sys_i);
    error_cnt++;
    final_report;
  end
endmodule : tb
